// file: pkg/simd_pkg.sv
// Constants, register map and operation codes of the packed-integer unit.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package simd_pkg;

  // --------------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] DEST_BASE   = 8'h00;
  localparam logic [7:0] SRC_BASE    = 8'h10;
  localparam logic [7:0] CTRL_ADDR   = 8'h20;
  localparam logic [7:0] CMD_ADDR    = 8'h24;
  localparam logic [7:0] STAT_ADDR   = 8'h28;
  localparam logic [7:0] RESULT_BASE = 8'h30;
  localparam logic [7:0] RESULT_LAST = 8'h3c;

  // --------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_IMM_LSB  = 8;
  localparam int CMD_GO_BIT    = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ZERO_BIT  = 1;
  localparam int STAT_CARRY_BIT = 2;
  localparam int STAT_ERR_BIT  = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_ff07;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------
  // Operation codes
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_MULTI_WINDOW_SAD  = 3'h0,
    OP_HORIZONTAL_MIN    = 3'h1,
    OP_PACKED_BIT_TEST   = 3'h2,
    OP_QWORD_EQUAL       = 3'h3,
    OP_DWORD_EQUAL       = 3'h4,
    OP_QWORD_GREATER     = 3'h5,
    OP_DWORD_WORD_PACK   = 3'h6
  } op_type;

endpackage

// file: design/axil_front.sv
// AXI4-Lite slave channel handling for the packed-integer unit.
// Assumes the owner decodes addresses combinationally and answers in time.
module axil_front
  import simd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic             reg_wr,
  output logic [7:0]       reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic        reg_werr,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rerr
);

  // ------------------------------------------------------------------
  // Write channels: address and data are held until both are present
  // ------------------------------------------------------------------
  logic aw_held;
  logic w_held;

  assign reg_wr = aw_held && w_held && !s_axil_bvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      s_axil_awready <= 1'b1;
      s_axil_wready  <= 1'b1;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= RESP_OKAY;
      reg_waddr      <= 8'h00;
      reg_wdata      <= 32'h0000_0000;
      reg_wstrb      <= 4'h0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held        <= 1'b1;
        s_axil_awready <= 1'b0;
        reg_waddr      <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held        <= 1'b1;
        s_axil_wready <= 1'b0;
        reg_wdata     <= s_axil_wdata;
        reg_wstrb     <= s_axil_wstrb;
      end
      if (reg_wr) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= reg_werr ? RESP_SLVERR : RESP_OKAY;
      end
      // Ready returns only after the response, so one write at a time
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid  <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read channel: data captured at the address handshake
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h0000_0000;
      s_axil_rresp   <= RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b1;
      s_axil_rdata   <= reg_rdata;
      s_axil_rresp   <= reg_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid  <= 1'b0;
      s_axil_arready <= 1'b1;
    end
  end

endmodule

// file: design/simd_packed_integer_ops.sv
// Packed-integer SIMD execution unit with its register file.
// Assumes software loads both operands, sets the operation, then starts it.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
module simd_packed_integer_ops
  import simd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready
);

  // ------------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                          input logic [7:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic [127:0] sad_calc(input logic [127:0] d,
                                            input logic [127:0] s,
                                            input logic [7:0]   imm);
    logic [31:0]  blk;
    logic [87:0]  win;
    logic [15:0]  acc;
    logic [127:0] r;
    blk = s[{imm[1:0], 5'h00} +: 32];
    win = imm[2] ? d[119:32] : d[87:0];
    r   = 128'h0;
    for (int i = 0; i < 8; i++) begin
      acc = 16'h0000;
      for (int k = 0; k < 4; k++) begin
        // Window i starts i bytes further into the destination
        acc = acc + {8'h00, abs_diff(win[(i + k) * 8 +: 8],
                                     blk[k * 8 +: 8])};
      end
      r[i * 16 +: 16] = acc;
    end
    sad_calc = r;
  endfunction

  function automatic logic [127:0] min_search(input logic [127:0] s);
    logic [15:0] val;
    logic [2:0]  idx;
    val = s[15:0];
    idx = 3'h0;
    for (int i = 1; i < 8; i++) begin
      // Strict compare keeps the lowest index on ties
      if (s[i * 16 +: 16] < val) begin
        val = s[i * 16 +: 16];
        idx = 3'(i);
      end
    end
    min_search = {109'h0, idx, val};
  endfunction

  function automatic logic [127:0] lane_equal(input logic [127:0] a,
                                              input logic [127:0] b,
                                              input logic         wide);
    logic [127:0] r;
    r = 128'h0;
    for (int i = 0; i < 4; i++) begin
      r[i * 32 +: 32] = (a[i * 32 +: 32] == b[i * 32 +: 32]) ?
                        32'hffff_ffff : 32'h0000_0000;
    end
    if (wide) begin
      for (int j = 0; j < 2; j++) begin
        r[j * 64 +: 64] = (a[j * 64 +: 64] == b[j * 64 +: 64]) ?
                          64'hffff_ffff_ffff_ffff : 64'h0;
      end
    end
    lane_equal = r;
  endfunction

  function automatic logic [127:0] qword_greater(input logic [127:0] a,
                                                 input logic [127:0] b);
    logic [127:0] r;
    r = 128'h0;
    for (int j = 0; j < 2; j++) begin
      r[j * 64 +: 64] = ($signed(a[j * 64 +: 64]) >
                         $signed(b[j * 64 +: 64])) ?
                        64'hffff_ffff_ffff_ffff : 64'h0;
    end
    qword_greater = r;
  endfunction

  function automatic logic [15:0] sat_word(input logic [31:0] x);
    if (x[31])
      sat_word = 16'h0000;
    else if (x[30:16] != 15'h0000)
      sat_word = 16'hffff;
    else
      sat_word = x[15:0];
  endfunction

  function automatic logic [127:0] pack_words(input logic [127:0] a,
                                              input logic [127:0] b);
    logic [127:0] r;
    r = 128'h0;
    for (int i = 0; i < 4; i++) begin
      r[i * 16 +: 16]       = sat_word(a[i * 32 +: 32]);
      r[64 + i * 16 +: 16]  = sat_word(b[i * 32 +: 32]);
    end
    pack_words = r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i])
        r[i * 8 +: 8] = data[i * 8 +: 8];
    end
    merge = r;
  endfunction

  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a[1:0] == 2'h0) &&
                 (a <= STAT_ADDR || (a >= RESULT_BASE && a <= RESULT_LAST));
  endfunction

  // ------------------------------------------------------------------
  // Bus front end
  // ------------------------------------------------------------------
  logic        reg_wr;
  logic [7:0]  reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_wstrb;
  logic        reg_werr;
  logic [31:0] reg_rdata;
  logic        reg_rerr;

  axil_front u_front (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .reg_wr         (reg_wr),
    .reg_waddr      (reg_waddr),
    .reg_wdata      (reg_wdata),
    .reg_wstrb      (reg_wstrb),
    .reg_werr       (reg_werr),
    .reg_rdata      (reg_rdata),
    .reg_rerr       (reg_rerr)
  );

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [127:0] dest_op;
  logic [127:0] src_op;
  logic [127:0] result;
  logic [31:0]  ctrl;
  logic         done;
  logic         zero_flag;
  logic         carry_flag;
  logic         op_error;
  logic         go;
  logic         clear_done;
  logic         clear_error;
  logic [2:0]   op_code;
  logic [7:0]   imm;

  assign op_code = ctrl[CTRL_OP_LSB +: 3];
  assign imm     = ctrl[CTRL_IMM_LSB +: 8];
  // Writes to the read-only result words answer with an error
  assign reg_werr = !addr_valid(reg_waddr) || (reg_waddr >= RESULT_BASE);
  assign reg_rerr = !addr_valid(s_axil_araddr);

  assign go          = reg_wr && reg_waddr == CMD_ADDR &&
                       reg_wstrb[0] && reg_wdata[CMD_GO_BIT];
  assign clear_done  = reg_wr && reg_waddr == STAT_ADDR &&
                       reg_wstrb[0] && reg_wdata[STAT_DONE_BIT];
  assign clear_error = reg_wr && reg_waddr == STAT_ADDR &&
                       reg_wstrb[0] && reg_wdata[STAT_ERR_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dest_op <= 128'h0;
      src_op  <= 128'h0;
      ctrl    <= CTRL_RESET;
    end else if (reg_wr && !reg_werr) begin
      if (reg_waddr < SRC_BASE)
        dest_op[{reg_waddr[3:2], 5'h00} +: 32] <=
          merge(dest_op[{reg_waddr[3:2], 5'h00} +: 32], reg_wdata, reg_wstrb);
      else if (reg_waddr < CTRL_ADDR)
        src_op[{reg_waddr[3:2], 5'h00} +: 32] <=
          merge(src_op[{reg_waddr[3:2], 5'h00} +: 32], reg_wdata, reg_wstrb);
      else if (reg_waddr == CTRL_ADDR)
        ctrl <= merge(ctrl, reg_wdata, reg_wstrb) & CTRL_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Execution: one cycle from the start command to the result
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result     <= 128'h0;
      zero_flag  <= 1'b0;
      carry_flag <= 1'b0;
    end else if (go) begin
      unique case (op_code)
        OP_MULTI_WINDOW_SAD: result <= sad_calc(dest_op, src_op, imm);
        OP_HORIZONTAL_MIN:   result <= min_search(src_op);
        OP_PACKED_BIT_TEST: begin
          zero_flag  <= ((dest_op & src_op) == 128'h0);
          carry_flag <= ((dest_op & ~src_op) == 128'h0);
        end
        OP_QWORD_EQUAL:      result <= lane_equal(dest_op, src_op, 1'b1);
        OP_DWORD_EQUAL:      result <= lane_equal(dest_op, src_op, 1'b0);
        OP_QWORD_GREATER:    result <= qword_greater(dest_op, src_op);
        OP_DWORD_WORD_PACK:  result <= pack_words(dest_op, src_op);
        // Unassigned code leaves result and flags as they were
        default: ;
      endcase
    end
  end

  // Bit test writes flags only; result keeps its previous contents

  // Sticky status: a set in the same cycle as a clear wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done     <= 1'b0;
      op_error <= 1'b0;
    end else begin
      if (go)
        done <= 1'b1;
      else if (clear_done)
        done <= 1'b0;
      if (go && op_code == 3'h7)
        op_error <= 1'b1;
      else if (clear_error)
        op_error <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------------
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (addr_valid(s_axil_araddr)) begin
      if (s_axil_araddr < SRC_BASE)
        reg_rdata = dest_op[{s_axil_araddr[3:2], 5'h00} +: 32];
      else if (s_axil_araddr < CTRL_ADDR)
        reg_rdata = src_op[{s_axil_araddr[3:2], 5'h00} +: 32];
      else if (s_axil_araddr == CTRL_ADDR)
        reg_rdata = ctrl;
      else if (s_axil_araddr == STAT_ADDR) begin
        reg_rdata[STAT_DONE_BIT] = done;
        reg_rdata[STAT_ZERO_BIT]  = zero_flag;
        reg_rdata[STAT_CARRY_BIT] = carry_flag;
        reg_rdata[STAT_ERR_BIT]  = op_error;
      end else if (s_axil_araddr >= RESULT_BASE)
        reg_rdata = result[{s_axil_araddr[3:2], 5'h00} +: 32];
    end
  end

endmodule

// file: tb/simd_checker_properties.sv
// Bus handshake checks for the packed-integer unit.
// Assumes it is bound to the unit's top module; one clock, one reset.
module simd_checker
  import simd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axil_awaddr,
  input wire logic        s_axil_awvalid,
  input wire logic        s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0]  s_axil_wstrb,
  input wire logic        s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic [7:0]  s_axil_araddr,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0]  s_axil_rresp,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------------
  AST_B_TIMING: assert property (s_axil_awvalid && s_axil_awready &&
    s_axil_wvalid && s_axil_wready |-> ##1 !s_axil_bvalid ##1 s_axil_bvalid)
    else $error("write answer not two edges after handshake");
  AST_AW_BLOCK: assert property (s_axil_awvalid && s_axil_awready
    |=> !s_axil_awready)
    else $error("address ready stayed high after accept");
  AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready
    |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped before taken");
  AST_B_BLOCK: assert property (s_axil_bvalid
    |-> !s_axil_awready && !s_axil_wready)
    else $error("new write accepted while response pending");
  AST_B_RELEASE: assert property (s_axil_bvalid && s_axil_bready
    |=> !s_axil_bvalid && s_axil_awready && s_axil_wready)
    else $error("write channel not freed after response");

  // ------------------------------------------------------------------
  // Read channels
  // ------------------------------------------------------------------
  AST_R_ANSWER: assert property (s_axil_arvalid && s_axil_arready
    |=> s_axil_rvalid)
    else $error("read data not one edge after address");
  AST_R_HOLD: assert property (s_axil_rvalid && !s_axil_rready
    |=> s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
    else $error("read data changed before taken");
  AST_AR_BLOCK: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read address accepted while data pending");
  AST_R_RELEASE: assert property (s_axil_rvalid && s_axil_rready
    |=> !s_axil_rvalid && s_axil_arready)
    else $error("read channel not freed after data");
  AST_ERR_ZERO: assert property (s_axil_rvalid &&
    s_axil_rresp == RESP_SLVERR |-> s_axil_rdata == 32'h0)
    else $error("refused read returned nonzero data");

  cover property (s_axil_bvalid && s_axil_bresp == RESP_SLVERR);
  cover property (s_axil_rvalid && s_axil_rresp == RESP_SLVERR);
  cover property (s_axil_rvalid && s_axil_rready);
  cover property (s_axil_rvalid && !s_axil_rready);
endmodule

bind simd_packed_integer_ops simd_checker chk_u (
  .mclk, .rst_n, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
  .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
  .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
  .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
  .s_axil_rvalid, .s_axil_rready
);

// file: tb/simd_packed_integer_ops_tb.sv
// Self-checking bench for the packed-integer unit.
// Drives the register bus itself; expectations come from a local model, except the reset, bit test and error checks.
module simd_packed_integer_ops_tb
  import simd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  logic [7:0]   s_axil_awaddr = 8'h00;
  logic         s_axil_awvalid = 1'b0;
  logic         s_axil_awready;
  logic [31:0]  s_axil_wdata = 32'h0;
  logic [3:0]   s_axil_wstrb = 4'hf;
  logic         s_axil_wvalid = 1'b0;
  logic         s_axil_wready;
  logic [1:0]   s_axil_bresp;
  logic         s_axil_bvalid;
  logic         s_axil_bready = 1'b0;
  logic [7:0]   s_axil_araddr = 8'h00;
  logic         s_axil_arvalid = 1'b0;
  logic         s_axil_arready;
  logic [31:0]  s_axil_rdata;
  logic [1:0]   s_axil_rresp;
  logic         s_axil_rvalid;
  logic         s_axil_rready = 1'b0;
  int           mismatches = 0;
  int           check_count = 0;
  int           cycles = 0;
  logic [127:0] res;
  logic [31:0]  st;

  always #25 mclk = ~mclk;

  simd_packed_integer_ops dut_u (
    .mclk, .rst_n, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
    .s_axil_rvalid, .s_axil_rready
  );

  // ------------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Whole run needs under 2000 cycles; the margin covers slow answers
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge mclk);
    s_axil_awaddr <= a;
    s_axil_awvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (s_axil_awvalid && s_axil_awready) begin
        aw_done = 1;
        s_axil_awvalid <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_done = 1;
        s_axil_wvalid <= 1'b0;
      end
    end
    while (!s_axil_bvalid) @(posedge mclk);
    // Answer is left waiting one cycle so the hold checks see a stall
    s_axil_bready <= 1'b1;
    @(posedge mclk);
    check(s_axil_bresp, er);
    s_axil_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    @(posedge mclk);
    while (!s_axil_arready) @(posedge mclk);
    s_axil_arvalid <= 1'b0;
    while (!s_axil_rvalid) @(posedge mclk);
    s_axil_rready <= 1'b1;
    @(posedge mclk);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  // Loads operands, starts the operation, reads result and status back
  task automatic run(input logic [127:0] d, input logic [127:0] s,
                     input logic [2:0] op, input logic [7:0] m);
    logic [31:0] w;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++) begin
      wr(DEST_BASE + 8'(4 * i), d[32*i+:32], RESP_OKAY);
      wr(SRC_BASE + 8'(4 * i), s[32*i+:32], RESP_OKAY);
    end
    wr(CTRL_ADDR, {16'h0, m, 5'h0, op}, RESP_OKAY);
    wr(CMD_ADDR, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      rd(RESULT_BASE + 8'(4 * i), w, r);
      res[32*i+:32] = w;
    end
    rd(STAT_ADDR, st, r);
  endtask

  // ------------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------------
  function automatic logic [127:0] model(input logic [127:0] d,
    input logic [127:0] s, input logic [2:0] op, input logic [7:0] m);
    logic [127:0]       r;
    logic [255:0]       ds;
    logic [15:0]        t;
    logic signed [31:0] v;
    int                 a;
    int                 b;
    r = '0;
    ds = {s, d};
    case (op)
      3'h0: for (int i = 0; i < 8; i++) begin
        t = 16'h0;
        for (int k = 0; k < 4; k++) begin
          a = d[8*(4*m[2]+i+k)+:8];
          b = s[8*(4*m[1:0]+k)+:8];
          t += 16'(a > b ? a - b : b - a);
        end
        r[16*i+:16] = t;
      end
      3'h1: begin
        r[15:0] = s[15:0];
        for (int i = 1; i < 8; i++) if (s[16*i+:16] < r[15:0]) begin
          r[15:0] = s[16*i+:16];
          r[18:16] = 3'(i);
        end
      end
      3'h3: for (int i = 0; i < 2; i++)
        r[64*i+:64] = {64{d[64*i+:64] == s[64*i+:64]}};
      3'h4: for (int i = 0; i < 4; i++)
        r[32*i+:32] = {32{d[32*i+:32] == s[32*i+:32]}};
      3'h5: for (int i = 0; i < 2; i++)
        r[64*i+:64] = {64{$signed(d[64*i+:64]) > $signed(s[64*i+:64])}};
      3'h6: for (int i = 0; i < 8; i++) begin
        v = ds[32*i+:32];
        r[16*i+:16] = v < 0 ? 16'h0 : (v > 32'sh0000ffff ? 16'hffff : v[15:0]);
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    logic [127:0] d;
    logic [127:0] s;
    logic [127:0] prev;
    logic [127:0] td [4];
    logic [127:0] ts [4];
    logic [31:0]  w;
    logic [1:0]   r;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CTRL_ADDR, w, r);
    check(w, CTRL_RESET);
    rd(STAT_ADDR, w, r);
    check(w, 32'h0);
    $display("test reset values done");
    d = 128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f;
    s = 128'h0a141e28_32465a64_ff00807f_01fe0210;
    for (int m = 0; m < 8; m++) begin
      run(d, s, 3'h0, 8'(m));
      check(res, model(d, s, 3'h0, 8'(m)));
      check(st[0], 1'b1);
    end
    $display("test window sums done");
    ts = '{128'h9000_0003_7fff_0003_8000_0003_ffff_1234,
           {16'h0005, {7{16'h0006}}}, 128'h0, 128'h0};
    for (int i = 0; i < 2; i++) begin
      run(d, ts[i], 3'h1, 8'h0);
      check(res, model(d, ts[i], 3'h1, 8'h0));
    end
    $display("test minimum search done");
    td = '{128'hff, 128'hff, 128'h0, d};
    ts = '{128'hff00, 128'h0fff, s, s};
    for (int i = 0; i < 4; i++) begin
      prev = res;
      run(td[i], ts[i], 3'h2, 8'h0);
      check(res, prev);
      check(st, {(td[i] & ~ts[i]) == 0, (td[i] & ts[i]) == 0, 1'b1});
    end
    $display("test bit test done");
    td = '{{64'hffff_ffff_ffff_ffff, 64'h0000_0005_0000_0009},
           {64'h8000_0000_0000_0000, 64'h7}, 128'h0, 128'h0};
    ts = '{{64'h1, 64'h0000_0005_0000_0008},
           {64'h8000_0000_0000_0000, 64'h7fff_ffff_0000_0007}, 128'h0, 128'h0};
    for (int i = 0; i < 6; i++) begin
      run(td[i/2], ts[i/2], 3'(3 + i % 3), 8'h0);
      check(res, model(td[i/2], ts[i/2], 3'(3 + i % 3), 8'h0));
    end
    $display("test compares done");
    d = 128'h0000_1234_0000_ffff_0001_0000_ffff_fffb;
    s = 128'h0000_abcd_0000_0000_8000_0000_7fff_ffff;
    run(d, s, 3'h6, 8'h0);
    check(res, model(d, s, 3'h6, 8'h0));
    $display("test pack done");
    prev = res;
    run(d, s, 3'h7, 8'h0);
    check(res, prev);
    check(st[3], 1'b1);
    wr(STAT_ADDR, 32'h9, RESP_OKAY);
    rd(STAT_ADDR, w, r);
    check(w & 32'h9, 32'h0);
    rd(8'h2c, w, r);
    check({r, w}, {RESP_SLVERR, 32'h0});
    wr(RESULT_BASE, 32'h5a5a_5a5a, RESP_SLVERR);
    rd(RESULT_BASE, w, r);
    check(w, prev[31:0]);
    s_axil_wstrb <= 4'h4;
    wr(DEST_BASE, 32'h0011_2233, RESP_OKAY);
    s_axil_wstrb <= 4'hf;
    rd(DEST_BASE, w, r);
    check(w, {d[31:24], 8'h11, d[15:0]});
    $display("test errors done");
    give_verdict();
  end
endmodule
